// >>> adcpp_pkg.sv
// Constants and types for the parallel host port and power-mode control.
// Assumes one 10 MHz clock and host pins that are asynchronous to it.
package adcpp_pkg;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int RES_W = 12;
  localparam int BYTE_W = 8;
  localparam int CHAN_W = 2;
  localparam int HBE_POS = 8;
  localparam int PM_HI_POS = 11;
  localparam int PM_LO_POS = 10;
  localparam int SYNC_W = RES_W + 6;

  // ****************************************
  // Reset values and timing counts
  // ****************************************
  localparam logic [RES_W-1:0] CTRL_RST = 12'h000;
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
  localparam logic [BYTE_W-1:0] LOW_BYTE_RST = 8'h00;
  localparam logic [3:0] CONV_EDGES = 4'hd;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_AUTO_SHDN = 2'b01,
    PM_AUTO_STBY = 2'b10,
    PM_FULL_SHDN = 2'b11
  } adcpp_pmode_t;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_RUN = 2'b01,
    CV_DONE = 2'b10
  } adcpp_conv_t;

endpackage

// >>> adcpp_sync.sv
// Two-stage synchroniser bank for the host pins and conversion clock.
// Assumes the clock enable freezes it along with the rest of the block.
`timescale 1ns/1ns
module adcpp_sync #(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [W-1:0] rst_val_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ****************************************
  // Metastability stages
  // ****************************************
  logic [W-1:0] meta_q;
  logic [W-1:0] stab_q;

  // Reset value is a constant at every instance
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      meta_q <= rst_val_in;
      stab_q <= rst_val_in;
    end else if (ce_in) begin
      meta_q <= async_in;
      stab_q <= meta_q;
    end
  end

  assign sync_out = stab_q;

endmodule

// >>> adcpp_port.sv
// Parallel host port and power-mode control of a 12-bit converter.
// Assumes host pins are asynchronous and result/channel come on mclk_in.
`timescale 1ns/1ns
module adcpp_port
  import adcpp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic word_mode_in,
  input wire logic convert_start_n_in,
  input wire logic conversion_clock_in,
  input wire logic [RES_W-1:0] db_in,
  input wire logic [RES_W-1:0] conv_result_in,
  input wire logic [CHAN_W-1:0] chan_id_in,
  output logic [RES_W-1:0] db_out,
  output logic [RES_W-1:0] db_oe_out,
  output logic busy_out,
  output logic track_out,
  output logic core_powered_out,
  output logic ref_powered_out,
  output logic [1:0] power_mode_out,
  output logic [RES_W-1:0] ctrl_word_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync_s;
  logic [RES_W-1:0] db_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic word_s;
  logic cnv_n_s;
  logic cclk_s;

  adcpp_sync #(
    .W(SYNC_W)
  ) u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .rst_val_in({6'h3e, 12'h000}),
    .async_in({cs_n_in, rd_n_in, wr_n_in, word_mode_in,
               convert_start_n_in, conversion_clock_in, db_in}),
    .sync_out(sync_s)
  );

  assign cs_n_s = sync_s[SYNC_W-1];
  assign rd_n_s = sync_s[SYNC_W-2];
  assign wr_n_s = sync_s[SYNC_W-3];
  assign word_s = sync_s[SYNC_W-4];
  assign cnv_n_s = sync_s[SYNC_W-5];
  assign cclk_s = sync_s[SYNC_W-6];
  assign db_s = sync_s[RES_W-1:0];

  // ****************************************
  // Strobes and edges
  // ****************************************
  logic rd_act;
  logic wr_act;
  logic wr_act_q;
  logic cnv_n_q;
  logic cclk_q;
  logic wr_rise;
  logic cnv_fall;
  logic cnv_rise;
  logic cclk_rise;
  logic hbe_s;

  // select and read gated as levels
  assign rd_act = !cs_n_s && !rd_n_s;
  assign wr_act = !cs_n_s && !wr_n_s;
  assign hbe_s = db_s[HBE_POS];

  // Reset to the synchronised idle levels so no edge is seen out of reset
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      wr_act_q <= 1'b0;
      cnv_n_q <= 1'b1;
      cclk_q <= 1'b0;
    end else if (ce_in) begin
      wr_act_q <= wr_act;
      cnv_n_q <= cnv_n_s;
      cclk_q <= cclk_s;
    end
  end

  assign wr_rise = wr_act_q && !wr_act;
  assign cnv_fall = cnv_n_q && !cnv_n_s;
  assign cnv_rise = !cnv_n_q && cnv_n_s;
  assign cclk_rise = !cclk_q && cclk_s;

  // ****************************************
  // Control register
  // ****************************************
  logic [RES_W-1:0] ctrl_q;
  logic [BYTE_W-1:0] low_byte_q;
  logic ctrl_load;
  logic [RES_W-1:0] ctrl_d;
  adcpp_pmode_t pmode;
  adcpp_pmode_t new_pmode;

  // two power bits pick the mode
  function automatic adcpp_pmode_t pm_decode(input logic [RES_W-1:0] w);
    pm_decode = adcpp_pmode_t'({w[PM_HI_POS], w[PM_LO_POS]});
  endfunction

  always_comb begin
    ctrl_load = 1'b0;
    ctrl_d = ctrl_q;
    if (wr_rise && word_s) begin
      ctrl_load = 1'b1;
      ctrl_d = db_s;
    end else if (wr_rise && hbe_s) begin
      // upper four bits join low byte
      // Host keeps bits 7..4 zero, so they are dropped
      ctrl_load = 1'b1;
      ctrl_d = {db_s[3:0], low_byte_q};
    end
  end

  assign pmode = pm_decode(ctrl_q);
  assign new_pmode = pm_decode(ctrl_d);

  // low byte is parked until high byte
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      low_byte_q <= LOW_BYTE_RST;
    end else if (ce_in) begin
      if (wr_rise && !word_s && !hbe_s) begin
        low_byte_q <= db_s[BYTE_W-1:0];
      end
    end
  end

  // reset leaves control word in normal
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      ctrl_q <= CTRL_RST;
    end else if (ce_in) begin
      if (ctrl_load) begin
        ctrl_q <= ctrl_d;
      end
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  adcpp_conv_t cv_q;
  logic [3:0] edge_cnt_q;
  logic [RES_W-1:0] result_q;
  logic [CHAN_W-1:0] chan_q;
  logic busy_q;
  logic conv_start;
  logic res_load;

  // Full shutdown ignores convert-start entirely
  assign conv_start = cnv_fall && (cv_q == CV_IDLE) &&
                      (pmode != PM_FULL_SHDN);
  assign res_load = (cv_q == CV_RUN) && cclk_rise &&
                    (edge_cnt_q == CONV_EDGES - 4'h1);

  // start on fall, finish on edge count
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      cv_q <= CV_IDLE;
      edge_cnt_q <= 4'h0;
    end else if (ce_in) begin
      case (cv_q)
        CV_IDLE: begin
          edge_cnt_q <= 4'h0;
          if (conv_start) begin
            cv_q <= CV_RUN;
          end
        end
        CV_RUN: begin
          if (res_load) begin
            cv_q <= CV_DONE;
          end else if (cclk_rise) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
          end
        end
        CV_DONE: begin
          cv_q <= CV_IDLE;
        end
        default: begin
          cv_q <= CV_IDLE;
        end
      endcase
    end
  end

  // result lands one cycle before busy drops
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      result_q <= RESULT_RST;
      chan_q <= '0;
    end else if (ce_in) begin
      if (res_load) begin
        result_q <= conv_result_in;
        chan_q <= chan_id_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      busy_q <= 1'b0;
    end else if (ce_in) begin
      if (conv_start) begin
        busy_q <= 1'b1;
      end else if (cv_q == CV_DONE) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Power and track-and-hold control
  // ****************************************
  logic core_pwr_q;
  logic ref_pwr_q;
  logic track_q;

  // Writes entering or leaving full shutdown win over convert-start events in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      core_pwr_q <= 1'b1;
      ref_pwr_q <= 1'b1;
      track_q <= 1'b0;
    end else if (ce_in) begin
      if (ctrl_load && new_pmode == PM_FULL_SHDN) begin
        // power down on the write edge
        core_pwr_q <= 1'b0;
        ref_pwr_q <= 1'b0;
        track_q <= 1'b0;
      end else if (ctrl_load && pmode == PM_FULL_SHDN) begin
        // leaving shutdown powers up and tracks
        core_pwr_q <= 1'b1;
        ref_pwr_q <= 1'b1;
        track_q <= 1'b1;
      end else if (res_load) begin
        case (pmode)
          PM_AUTO_SHDN: begin
            core_pwr_q <= 1'b0;
            ref_pwr_q <= 1'b0;
            track_q <= 1'b0;
          end
          PM_AUTO_STBY: begin
            core_pwr_q <= 1'b0;
            track_q <= 1'b0;
          end
          default: begin
            track_q <= 1'b1;
          end
        endcase
      end else if (conv_start) begin
        track_q <= 1'b0;
      end else if (cnv_rise && pmode != PM_FULL_SHDN) begin
        core_pwr_q <= 1'b1;
        ref_pwr_q <= 1'b1;
        track_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  logic [RES_W-1:0] db_q;
  logic [RES_W-1:0] rd_res;
  logic [CHAN_W-1:0] rd_chan;

  // fresh result bypasses its register, bus leads busy
  assign rd_res = res_load ? conv_result_in : result_q;
  assign rd_chan = res_load ? chan_id_in : chan_q;

  // Registered every cycle, so data trails the strobe by one edge
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      db_q <= '0;
    end else if (ce_in) begin
      if (word_s) begin
        // full word, pin 8 is data
        db_q <= rd_res;
      end else if (hbe_s) begin
        db_q <= {4'h0, 2'b00, rd_chan, rd_res[RES_W-1:BYTE_W]};
      end else begin
        db_q <= {4'h0, rd_res[BYTE_W-1:0]};
      end
    end
  end

  // byte mode leaves pins 11..8 as inputs
  // drive only while both strobes low
  assign db_oe_out = !rd_act ? 12'h000 :
                     (word_s ? 12'hfff : 12'h0ff);
  assign db_out = db_q;

  assign busy_out = busy_q;
  assign track_out = track_q;
  assign core_powered_out = core_pwr_q;
  assign ref_powered_out = ref_pwr_q;
  assign power_mode_out = pmode;
  assign ctrl_word_out = ctrl_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_word_read_data: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    rd_act && word_s && !res_load |=> db_out == $past(result_q))
    else $error("word read data wrong");

  a_low_byte_data: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    rd_act && !word_s && !hbe_s && !res_load
    |=> db_out[7:0] == $past(result_q[7:0]) && db_oe_out[8] == 1'b0)
    else $error("low byte data wrong");

  a_high_byte_data: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    rd_act && !word_s && hbe_s && !res_load
    |=> db_out[7:0] == {2'b00, $past(chan_q), $past(result_q[11:8])})
    else $error("high byte data wrong");

  a_bus_release: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (db_oe_out != 12'h000) == rd_act)
    else $error("bus driven outside read");

  a_result_before_busy: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    $fell(busy_q) |-> $past(res_load, 2))
    else $error("busy fell before result");

  a_word_write_load: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    wr_rise && word_s |=> ctrl_q == $past(db_s))
    else $error("word write not loaded");

  a_low_byte_parked: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    wr_rise && !word_s && !hbe_s |=> $stable(ctrl_q))
    else $error("low byte applied early");

  a_full_shdn_entry: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    ctrl_load && new_pmode == PM_FULL_SHDN
    |=> !core_pwr_q && !ref_pwr_q && !track_q)
    else $error("full shutdown not entered");

  a_auto_shdn_off: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    res_load && pmode == PM_AUTO_SHDN && !ctrl_load
    |=> !core_pwr_q && !ref_pwr_q ##1 busy_q == 1'b0)
    else $error("autoshutdown did not power off");

  a_conv_busy: assert property (
    @(posedge mclk_in) disable iff (!rstn_in || !ce_in)
    conv_start |=> busy_q && !track_q)
    else $error("busy not raised on start");

  a_reset_normal: assert property (
    @(posedge mclk_in)
    !rstn_in |=> pmode == PM_NORMAL && core_pwr_q && !track_q)
    else $error("reset not in normal mode");

endmodule

// >>> adcpp_bus_model.sv
// Host-side data bus wire model for the parallel port.
// Assumes host and device enables change only after mclk_in edges.
`timescale 1ns/1ns
module adcpp_bus_model
  import adcpp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [RES_W-1:0] host_oe_in,
  input wire logic [RES_W-1:0] host_db_in,
  input wire logic [RES_W-1:0] dev_oe_in,
  input wire logic [RES_W-1:0] dev_db_in,
  output logic [RES_W-1:0] bus_out
);
  // ****
  // Floating lines
  // ****
  // Released bits toggle so a stale value never passes
  logic [RES_W-1:0] float_q = 12'h5a5;

  always_ff @(posedge mclk_in) begin
    float_q <= ~float_q;
  end

  // ****
  // Wire resolution
  // ****
  // host drives select while device drives bytes
  always_comb begin
    for (int i = 0; i < RES_W; i++) begin
      if (host_oe_in[i]) begin
        bus_out[i] = host_db_in[i];
      end else if (dev_oe_in[i]) begin
        bus_out[i] = dev_db_in[i];
      end else begin
        bus_out[i] = float_q[i];
      end
    end
  end
endmodule

// >>> adcpp_tb.sv
// Self-checking bench for the parallel host port and power modes.
// Assumes one 10 MHz clock; the bench plays host and converter core.
`timescale 1ns/1ns
module testbench
  import adcpp_pkg::*;
;
  // ****
  // Signals
  // ****
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, wmode = 1'b1;
  logic convert_start_n_n = 1'b1, cclk = 1'b0, cclk_en = 1'b0, ce = 1'b1;
  logic [1:0] cdiv = 2'b00, chan = 2'b00;
  logic [RES_W-1:0] host_db = 12'h000, host_oe = 12'h000;
  logic [RES_W-1:0] result = 12'h000, db_in, db_out, db_oe;
  logic busy, track, core_on, ref_on;
  logic [1:0] pmode;
  logic [RES_W-1:0] ctrl;
  int errors = 0, n_compared = 0, cyc = 0;

  always #50 mclk_in = ~mclk_in;

  // Slow conversion clock, 8 system cycles a period
  always @(posedge mclk_in) begin
    cdiv <= cdiv + 2'b01;
    if (cclk_en && cdiv == 2'b11) begin
      cclk <= ~cclk;
    end
  end

  adcpp_port uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .word_mode_in(wmode), .convert_start_n_in(convert_start_n_n),
    .conversion_clock_in(cclk), .db_in(db_in), .conv_result_in(result),
    .chan_id_in(chan), .db_out(db_out), .db_oe_out(db_oe),
    .busy_out(busy), .track_out(track), .core_powered_out(core_on),
    .ref_powered_out(ref_on), .power_mode_out(pmode),
    .ctrl_word_out(ctrl));

  adcpp_bus_model bus (.mclk_in(mclk_in), .host_oe_in(host_oe),
    .host_db_in(host_db), .dev_oe_in(db_oe), .dev_db_in(db_out),
    .bus_out(db_in));

  // ****
  // Tasks
  // ****
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [RES_W-1:0] got,
                       input logic [RES_W-1:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic wr(input logic word, input logic [RES_W-1:0] d);
    @(posedge mclk_in);
    wmode <= word;
    host_oe <= 12'hfff;
    host_db <= d;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    tick(4);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    // Data held past the strobe rise for the sync delay
    tick(4);
    host_oe <= 12'h000;
    tick(2);
    @(negedge mclk_in);
  endtask

  task automatic rd(input logic word, input logic hb,
                    input logic [RES_W-1:0] exp, input logic [RES_W-1:0] m);
    @(posedge mclk_in);
    wmode <= word;
    host_oe <= word ? 12'h000 : 12'h100;
    host_db <= {3'b000, hb, 8'h00};
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    tick(4);
    @(negedge mclk_in);
    check(db_oe, m, "read enable");
    check(db_in & m, exp, "read data");
    @(posedge mclk_in);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    host_oe <= 12'h000;
    tick(3);
    @(negedge mclk_in);
    check(db_oe, 12'h000, "bus released");
  endtask

  task automatic conv(input logic tied_read);
    int k;
    logic [RES_W-1:0] last;
    @(posedge mclk_in);
    convert_start_n_n <= 1'b0;
    cclk_en <= 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 8) begin
      @(negedge mclk_in);
      k++;
    end
    check({11'h000, busy}, 12'h001, "busy rise");
    while (busy !== 1'b0 && k < 400) begin
      last = db_in;
      @(negedge mclk_in);
      k++;
    end
    check({11'h000, busy}, 12'h000, "busy fall");
    if (tied_read) begin
      check(last, result, "tied read before busy fall");
    end
    @(posedge mclk_in);
    cclk_en <= 1'b0;
  endtask

  task automatic power(input logic c, input logic r, input logic t);
    check({9'h000, core_on, ref_on, track}, {9'h000, c, r, t}, "power");
  endtask

  // ****
  // Hang guard
  // ****
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      test_done();
    end
  end

  // ****
  // Tests
  // ****
  initial begin
    tick(4);
    rstn_in <= 1'b1;
    @(negedge mclk_in);
    check(ctrl, 12'h000, "ctrl reset");
    check({10'h000, pmode}, 12'h000, "mode reset");
    power(1'b1, 1'b1, 1'b0);
    check(db_oe, 12'h000, "idle bus");
    $display("test reset done");
    wr(1'b1, 12'h0a5);
    check(ctrl, 12'h0a5, "word write");
    @(posedge mclk_in);
    result <= 12'h9c3;
    chan <= 2'b10;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    conv(1'b1);
    @(negedge mclk_in);
    power(1'b1, 1'b1, 1'b1);
    @(posedge mclk_in);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    convert_start_n_n <= 1'b1;
    tick(3);
    rd(1'b1, 1'b0, 12'h9c3, 12'hfff);
    rd(1'b0, 1'b0, 12'h0c3, 12'h0ff);
    rd(1'b0, 1'b1, 12'h029, 12'h0ff);
    $display("test read done");
    wr(1'b0, 12'h05a);
    check(ctrl, 12'h0a5, "low byte held");
    wr(1'b0, 12'h103);
    check(ctrl, 12'h35a, "byte write");
    $display("test byte write done");
    for (int m = 1; m < 3; m++) begin
      wr(1'b1, {m[1:0], 10'h0a5});
      check({10'h000, pmode}, m[11:0], "mode bits");
      conv(1'b0);
      // Convert-start idles low while powered down
      tick(20);
      @(negedge mclk_in);
      power(1'b0, m == 2, 1'b0);
      check(ctrl, {m[1:0], 10'h0a5}, "ctrl kept");
      @(posedge mclk_in);
      convert_start_n_n <= 1'b1;
      // Power-up wait shortened; not enforced by the port
      tick(6);
      @(negedge mclk_in);
      power(1'b1, 1'b1, 1'b1);
    end
    $display("test auto modes done");
    wr(1'b1, 12'hc00);
    power(1'b0, 1'b0, 1'b0);
    @(posedge mclk_in);
    convert_start_n_n <= 1'b0;
    tick(40);
    @(negedge mclk_in);
    check({11'h000, busy}, 12'h000, "no start off");
    power(1'b0, 1'b0, 1'b0);
    @(posedge mclk_in);
    convert_start_n_n <= 1'b1;
    wr(1'b1, 12'h000);
    power(1'b1, 1'b1, 1'b1);
    check(ctrl, 12'h000, "mode normal");
    $display("test full shutdown done");
    // Clock enable low freezes pins, so this write never lands
    @(posedge mclk_in);
    ce <= 1'b0;
    wr(1'b1, 12'h400);
    @(posedge mclk_in);
    ce <= 1'b1;
    tick(4);
    @(negedge mclk_in);
    check(ctrl, 12'h000, "frozen write");
    $display("test clock enable done");
    test_done();
  end
endmodule
